/* File: design/ref_capture.sv */
// reference capture, skew check, timestamp and monitor logic
// What this block does
// - sync mode bit 1 selects timestamp method, 0 selects normal sync.
// - timestamp mode never resets clocks; marks the coincident sample instead.
// - enabled control bit whose function selector equals 5 carries the timestamp.
// - timestamp delay register shifts which sample gets marked.
// - no timestamp is launched by an event seen while a decimating mode is active.
// - mode write of 1 or 2 selects input type and arms capture machine.
// - counted shot mode field clears itself after the acted event.
// - normal mode event syncs divider, downconverters, monitor and link.
// - bit 4 picks falling event, bit 3 picks falling clock capture.
// - counted shot ignores programmed number of events before acting.
// - continuous mode resyncs link when edge misses aligned clock.
// - once continuous mode has locked, captures inside the skew window leave dividers undisturbed.
// - negative skew is before phase zero, positive skew after.
// - monitor register shows hold status high, setup status low.
// - monitor codes are read as setup, hold or valid margin.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module ref_capture
    import refcap_pkg::*;
(
    input  wire logic        ref_clk_i,     // sample clock
    input  wire logic        rstn_i,        // sync reset, active low
    input  wire logic [11:0] reg_addr_i,    // register address
    input  wire logic [7:0]  reg_wdata_i,   // register write data
    input  wire logic        reg_wr_i,      // write strobe
    input  wire logic        reg_rd_i,      // read strobe
    output logic      [7:0]  reg_rdata_o,   // read data, cycle after strobe
    input  wire logic        ref_rise_i,    // reference sampled on rising clk
    input  wire logic        ref_fall_i,    // reference sampled on falling clk
    input  wire logic [3:0]  setup_det_i,   // setup detector status
    input  wire logic [3:0]  hold_det_i,    // hold detector status
    input  wire logic        decimation_i,  // decimating mode active
    output logic             div_sync_o,    // input divider sync pulse
    output logic             digital_downconverter_sync_o, // sync pulse
    output logic             mon_sync_o,    // signal monitor sync pulse
    output logic             link_sync_o,   // link sync pulse
    output logic             link_resync_o, // link resync pulse
    output logic      [2:0]  ts_ctrl_a_o,   // control bits, channel a
    output logic      [2:0]  ts_ctrl_b_o    // control bits, channel b
);

    typedef struct packed {
        logic [2:0]  clk_div;
        logic        pol_fall;
        logic        edge_fall;
        logic [1:0]  mode;
        logic [1:0]  win_neg;
        logic [1:0]  win_pos;
        logic [7:0]  ts_delay;
        logic        ts_mode;
        logic [2:0]  fn0;
        logic [2:0]  fn1;
        logic [2:0]  fn2;
        logic [1:0]  cb_count;
        logic [3:0]  ign_cfg;
        logic [7:0]  lmfc_len;
        logic [3:0]  ign_cnt;
        logic [7:0]  phase;
        logic        locked;
        cap_state_e  st;
        logic        rise_s1;
        logic        rise_s2;
        logic        fall_s1;
        logic        fall_s2;
        logic        ref_prev;
        logic [3:0]  setup_s1;
        logic [3:0]  setup_s2;
        logic [3:0]  hold_s1;
        logic [3:0]  hold_s2;
        logic [7:0]  monitor;
        logic        ts_pend;
        logic [7:0]  ts_cnt;
        logic [2:0]  ts_bits;
        logic        sync;
        logic        resync;
        logic [7:0]  rdata;
    } state_s;

    state_s r;
    state_s n;

    logic       ref_sel;
    logic       ev;
    logic       phase_last;
    logic       in_window;
    logic       do_sync;
    logic       do_ts;
    logic       misaligned;
    logic [2:0] ts_mask;
    logic [2:0] cb_enable;
    logic       wr_ctrl;

    always_comb begin
        n          = r;
        do_sync    = 1'b0;
        do_ts      = 1'b0;
        misaligned = 1'b0;
        wr_ctrl    = reg_wr_i && (reg_addr_i == OFF_CTRL);

        // two-flop synchronisers on the reference and detector inputs
        n.rise_s1  = ref_rise_i;
        n.rise_s2  = r.rise_s1;
        n.fall_s1  = ref_fall_i;
        n.fall_s2  = r.fall_s1;
        n.setup_s1 = setup_det_i;
        n.setup_s2 = r.setup_s1;
        n.hold_s1  = hold_det_i;
        n.hold_s2  = r.hold_s1;

        // capture clock edge and event polarity
        ref_sel    = r.edge_fall ? r.fall_s2 : r.rise_s2;
        n.ref_prev = ref_sel;
        ev = r.pol_fall ? (r.ref_prev && !ref_sel)
                        : (!r.ref_prev && ref_sel);

        // local multiframe phase counter
        phase_last = (r.lmfc_len <= 8'h01) ||
                     (r.phase >= r.lmfc_len - 8'h01);
        n.phase    = phase_last ? 8'h00 : r.phase + 8'h01;

        // window: after phase zero up to pos, before it down to neg
        in_window = (r.phase == 8'h00) ||
                    (r.phase <= {6'h00, r.win_pos}) ||
                    ((r.win_neg != 2'h0) &&
                     (r.phase >= r.lmfc_len - {6'h00, r.win_neg}));

        // control bit mask: selector code, limited to enabled bits
        cb_enable = (r.cb_count == 2'h1) ? 3'h4 :
                    (r.cb_count == 2'h2) ? 3'h6 :
                    (r.cb_count == 2'h3) ? 3'h7 : 3'h0;
        ts_mask   = {r.fn2 == FN_REF_TS,
                     r.fn1 == FN_REF_TS,
                     r.fn0 == FN_REF_TS} & cb_enable;

        case (r.st)
            ST_SHOT: begin
                if (ev) begin
                    if (r.ign_cnt != 4'h0) begin
                        n.ign_cnt = r.ign_cnt - 4'h1;
                    end else begin
                        n.mode = MODE_OFF;
                        n.st   = ST_IDLE;
                        if (r.ts_mode) begin
                            do_ts = 1'b1;
                        end else begin
                            do_sync = 1'b1;
                        end
                    end
                end
            end
            ST_CONT: begin
                if (ev) begin
                    if (r.ts_mode) begin
                        do_ts = 1'b1;
                    end else if (!r.locked) begin
                        do_sync  = 1'b1;
                        n.locked = 1'b1;
                    end else if (!in_window) begin
                        do_sync    = 1'b1;
                        misaligned = 1'b1;
                    end
                end
            end
            default: begin
            end
        endcase

        // normal mode realigns the multiframe phase to this edge
        if (do_sync) begin
            n.phase = (r.lmfc_len <= 8'h01) ? 8'h00 : 8'h01;
        end
        n.sync   = do_sync;
        n.resync = misaligned;

        // monitor keeps margin seen at each detected edge
        if (ev) begin
            n.monitor = {r.hold_s2, r.setup_s2};
        end

        // timestamp delay and single sample mark
        n.ts_bits = 3'h0;
        if (r.ts_pend) begin
            if (r.ts_cnt == 8'h00) begin
                n.ts_bits = ts_mask;
                n.ts_pend = 1'b0;
            end else begin
                n.ts_cnt = r.ts_cnt - 8'h01;
            end
        end
        if (do_ts && !decimation_i) begin
            n.ts_pend = 1'b1;
            n.ts_cnt  = r.ts_delay;
        end

        // register writes; a fresh arm beats the self clear
        if (reg_wr_i) begin
            if (reg_addr_i == OFF_CLK_DIV) begin
                n.clk_div = reg_wdata_i[2:0];
            end else if (wr_ctrl) begin
                n.pol_fall  = reg_wdata_i[CTRL_POL_BIT];
                n.edge_fall = reg_wdata_i[CTRL_EDGE_BIT];
                n.mode      = reg_wdata_i[CTRL_MODE_LO +: 2];
                n.ign_cnt   = r.ign_cfg;
                n.locked    = 1'b0;
                if (reg_wdata_i[CTRL_MODE_LO +: 2] == MODE_CONT) begin
                    n.st = ST_CONT;
                end else if (reg_wdata_i[CTRL_MODE_LO +: 2] == MODE_SHOT) begin
                    n.st = ST_SHOT;
                end else begin
                    n.st = ST_IDLE;
                end
            end else if (reg_addr_i == OFF_WINDOW) begin
                n.win_neg = reg_wdata_i[WIN_NEG_LO +: 2];
                n.win_pos = reg_wdata_i[WIN_POS_LO +: 2];
            end else if (reg_addr_i == OFF_TS_DELAY) begin
                n.ts_delay = reg_wdata_i;
            end else if (reg_addr_i == OFF_IGNORE) begin
                n.ign_cfg = reg_wdata_i[3:0];
            end else if (reg_addr_i == OFF_LMFC_LEN) begin
                n.lmfc_len = reg_wdata_i;
            end else if (reg_addr_i == OFF_SYNC_MODE) begin
                n.ts_mode = reg_wdata_i[0];
            end else if (reg_addr_i == OFF_FN_LOW) begin
                n.fn0 = reg_wdata_i[FN0_LO +: 3];
                n.fn1 = reg_wdata_i[FN1_LO +: 3];
            end else if (reg_addr_i == OFF_FN_HIGH) begin
                n.fn2 = reg_wdata_i[FN2_LO +: 3];
            end else if (reg_addr_i == OFF_CB_COUNT) begin
                n.cb_count = reg_wdata_i[CB_COUNT_LO +: 2];
            end
        end

        // read data stands only in the cycle after the strobe
        n.rdata = 8'h00;
        if (reg_rd_i) begin
            if (reg_addr_i == OFF_CLK_DIV) begin
                n.rdata = {5'h00, r.clk_div};
            end else if (reg_addr_i == OFF_CTRL) begin
                n.rdata = {3'h0, r.pol_fall, r.edge_fall, r.mode, 1'b0};
            end else if (reg_addr_i == OFF_WINDOW) begin
                n.rdata = {4'h0, r.win_neg, r.win_pos};
            end else if (reg_addr_i == OFF_TS_DELAY) begin
                n.rdata = r.ts_delay;
            end else if (reg_addr_i == OFF_IGNORE) begin
                n.rdata = {4'h0, r.ign_cfg};
            end else if (reg_addr_i == OFF_LMFC_LEN) begin
                n.rdata = r.lmfc_len;
            end else if (reg_addr_i == OFF_STATUS) begin
                n.rdata = {1'b0, r.st, r.locked, r.ign_cnt};
            end else if (reg_addr_i == OFF_MONITOR) begin
                n.rdata = r.monitor;
            end else if (reg_addr_i == OFF_SYNC_MODE) begin
                n.rdata = {7'h00, r.ts_mode};
            end else if (reg_addr_i == OFF_FN_LOW) begin
                n.rdata = {1'b0, r.fn1, 1'b0, r.fn0};
            end else if (reg_addr_i == OFF_FN_HIGH) begin
                n.rdata = {5'h00, r.fn2};
            end else if (reg_addr_i == OFF_CB_COUNT) begin
                n.rdata = {r.cb_count, 6'h00};
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            r          <= '0;
            r.clk_div  <= RST_CLK_DIV;
            r.mode     <= RST_MODE;
            r.ts_delay <= RST_TS_DELAY;
            r.ign_cfg  <= RST_IGNORE;
            r.lmfc_len <= RST_LMFC_LEN;
            r.fn0      <= RST_FN;
            r.fn1      <= RST_FN;
            r.fn2      <= RST_FN;
            r.cb_count <= RST_CB_COUNT;
            r.st       <= ST_IDLE;
        end else begin
            r <= n;
        end
    end

    assign reg_rdata_o                  = r.rdata;
    assign div_sync_o                   = r.sync;
    assign digital_downconverter_sync_o = r.sync;
    assign mon_sync_o                   = r.sync;
    assign link_sync_o                  = r.sync;
    assign link_resync_o                = r.resync;
    assign ts_ctrl_a_o                  = r.ts_bits;
    assign ts_ctrl_b_o                  = r.ts_bits;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    sequence shot_fire_s;
        r.st == ST_SHOT && ev && r.ign_cnt == 4'h0 && !wr_ctrl;
    endsequence

    sequence shot_skip_s;
        r.st == ST_SHOT && ev && r.ign_cnt != 4'h0 && !wr_ctrl;
    endsequence

    sequence ts_launch_s;
        do_ts && !decimation_i && r.ts_delay == 8'h00 && !r.ts_pend;
    endsequence

    shot_self_clear_a: assert property (
        shot_fire_s |=> r.mode == MODE_OFF && r.st == ST_IDLE)
        else $error("counted shot mode did not clear itself");

    ignore_count_a: assert property (
        shot_skip_s |=> r.ign_cnt == $past(r.ign_cnt) - 4'h1 && !div_sync_o)
        else $error("ignored event not counted down");

    normal_sync_a: assert property (
        shot_fire_s and !r.ts_mode |=> div_sync_o && link_sync_o)
        else $error("normal mode event gave no sync pulse");

    ts_no_reset_a: assert property (
        div_sync_o |-> !$past(r.ts_mode))
        else $error("clocks resynced in timestamp mode");

    ts_delay_zero_a: assert property (
        ts_launch_s ##0 (ts_mask != 3'h0)
        |-> ##2 ts_ctrl_a_o == $past(ts_mask))
        else $error("timestamp not on expected sample");

    ts_one_sample_a: assert property (
        ts_ctrl_a_o != 3'h0 |=> ts_ctrl_a_o == 3'h0 && ts_ctrl_b_o == 3'h0)
        else $error("timestamp marked more than one sample");

    decim_block_a: assert property (
        r.ts_mode && decimation_i && !r.ts_pend |=> !r.ts_pend)
        else $error("timestamp launched while decimating");

    window_quiet_a: assert property (
        r.st == ST_CONT && !r.ts_mode && r.locked && ev && r.phase == 8'h00
        |=> !link_resync_o && !div_sync_o)
        else $error("aligned edge disturbed dividers");

    outside_resync_a: assert property (
        r.st == ST_CONT && !r.ts_mode && r.locked && ev && !in_window
        |=> link_resync_o ##1 !link_resync_o)
        else $error("misaligned edge gave no resync pulse");

    monitor_capture_a: assert property (
        ev |=> r.monitor == {$past(r.hold_s2), $past(r.setup_s2)})
        else $error("monitor did not capture margin at event");

endmodule : ref_capture

/* File: design/refcap_pkg.sv */
// constants and types for the reference capture block
package refcap_pkg;

    // register offsets
    localparam logic [11:0] OFF_CLK_DIV   = 12'h10b;
    localparam logic [11:0] OFF_CTRL      = 12'h120;
    localparam logic [11:0] OFF_WINDOW    = 12'h122;
    localparam logic [11:0] OFF_TS_DELAY  = 12'h123;
    localparam logic [11:0] OFF_IGNORE    = 12'h124;
    localparam logic [11:0] OFF_LMFC_LEN  = 12'h125;
    localparam logic [11:0] OFF_STATUS    = 12'h126;
    localparam logic [11:0] OFF_MONITOR   = 12'h128;
    localparam logic [11:0] OFF_SYNC_MODE = 12'h1ff;
    localparam logic [11:0] OFF_FN_LOW    = 12'h559;
    localparam logic [11:0] OFF_FN_HIGH   = 12'h55a;
    localparam logic [11:0] OFF_CB_COUNT  = 12'h58f;

    // field positions
    localparam int CTRL_POL_BIT   = 4;
    localparam int CTRL_EDGE_BIT  = 3;
    localparam int CTRL_MODE_LO   = 1;
    localparam int WIN_NEG_LO     = 2;
    localparam int WIN_POS_LO     = 0;
    localparam int FN0_LO         = 0;
    localparam int FN1_LO         = 4;
    localparam int FN2_LO         = 0;
    localparam int CB_COUNT_LO    = 6;
    localparam int STAT_LOCK_BIT  = 4;
    localparam int STAT_ST_LO     = 5;

    // encodings
    localparam logic [1:0] MODE_OFF  = 2'h0;
    localparam logic [1:0] MODE_CONT = 2'h1;
    localparam logic [1:0] MODE_SHOT = 2'h2;
    localparam logic [2:0] FN_REF_TS = 3'h5;

    // values after reset
    localparam logic [2:0] RST_CLK_DIV  = 3'h0;
    localparam logic [1:0] RST_MODE     = 2'h0;
    localparam logic [7:0] RST_TS_DELAY = 8'h00;
    localparam logic [3:0] RST_IGNORE   = 4'h0;
    localparam logic [7:0] RST_LMFC_LEN = 8'h20;
    localparam logic [2:0] RST_FN       = 3'h0;
    localparam logic [1:0] RST_CB_COUNT = 2'h0;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHOT,
        ST_CONT
    } cap_state_e;

endpackage : refcap_pkg

/* File: sim/ref_source.sv */
// behavioural reference generator and capture margin detectors
`timescale 1ns/100ps
module ref_source (
    input  wire logic       ref_clk_i,  // sample clock
    output logic            ref_rise_o, // level, rising-edge capture
    output logic            ref_fall_o, // level, falling-edge capture
    output logic      [3:0] setup_o,    // setup detector code
    output logic      [3:0] hold_o      // hold detector code
);
    int cyc      = 0;
    int edge_cyc = 0;

    initial begin
        ref_rise_o = 1'b0;
        ref_fall_o = 1'b0;
        setup_o    = 4'h8;
        hold_o     = 4'h0;
    end

    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
    end

    // one pulse on the chosen capture path; idle level is low
    task automatic pulse(input bit on_fall, input int hi, input int lo);
        @(posedge ref_clk_i);
        edge_cyc = cyc;
        if (on_fall) ref_fall_o <= 1'b1;
        else ref_rise_o <= 1'b1;
        repeat ((hi < 2) ? 2 : hi) @(posedge ref_clk_i);
        if (on_fall) ref_fall_o <= 1'b0;
        else ref_rise_o <= 1'b0;
        repeat (lo - 1) @(posedge ref_clk_i);
    endtask : pulse

    // detector codes that read as a valid margin
    task automatic set_det(input logic [3:0] s, input logic [3:0] h);
        @(posedge ref_clk_i);
        setup_o <= s;
        hold_o  <= h;
    endtask : set_det
endmodule : ref_source

/* File: sim/ref_capture_bench.sv */
// self-checking bench for the reference capture block
`timescale 1ns/100ps
`define CHK(g, e) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end
module ref_capture_bench;
    import refcap_pkg::*;
    localparam int LIMIT = 20000;
    logic        ref_clk_i    = 1'b0;
    logic        rstn_i       = 1'b0;
    logic [11:0] reg_addr_i   = 12'h000;
    logic [7:0]  reg_wdata_i  = 8'h00;
    logic        reg_wr_i     = 1'b0;
    logic        reg_rd_i     = 1'b0;
    logic        decimation_i = 1'b0;
    logic [7:0]  reg_rdata_o;
    logic        ref_rise;
    logic        ref_fall;
    logic [3:0]  setup_det;
    logic [3:0]  hold_det;
    logic        div_sync_o;
    logic        dconv_sync;
    logic        mon_sync_o;
    logic        link_sync_o;
    logic        link_resync_o;
    logic [2:0]  ts_ctrl_a_o;
    logic [2:0]  ts_ctrl_b_o;
    logic [2:0]  ts_val = 3'h0;
    int n_mismatch = 0, comparisons = 0, cycles = 0, lat0 = 0;
    int n_sync = 0, n_resync = 0, n_ts = 0, sync_cyc = 0, ts_cyc = 0;

    ref_source src (.ref_clk_i(ref_clk_i), .ref_rise_o(ref_rise),
        .ref_fall_o(ref_fall), .setup_o(setup_det), .hold_o(hold_det));

    ref_capture dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .ref_rise_i(ref_rise), .ref_fall_i(ref_fall),
        .setup_det_i(setup_det), .hold_det_i(hold_det),
        .decimation_i(decimation_i), .div_sync_o(div_sync_o),
        .digital_downconverter_sync_o(dconv_sync), .mon_sync_o(mon_sync_o),
        .link_sync_o(link_sync_o), .link_resync_o(link_resync_o),
        .ts_ctrl_a_o(ts_ctrl_a_o), .ts_ctrl_b_o(ts_ctrl_b_o));

    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (div_sync_o) begin
            n_sync   <= n_sync + 1;
            sync_cyc <= src.cyc;
        end
        if (link_resync_o) n_resync <= n_resync + 1;
        if (ts_ctrl_a_o != 3'h0) begin
            n_ts   <= n_ts + 1;
            ts_cyc <= src.cyc;
            ts_val <= ts_ctrl_a_o;
        end
        if (rstn_i) begin
            `CHK({dconv_sync, mon_sync_o, link_sync_o}, {3{div_sync_o}})
            `CHK(ts_ctrl_b_o, ts_ctrl_a_o)
        end
        if (cycles == LIMIT) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i   <= 1'b0;
        #1 d = reg_rdata_o;
    endtask : rd

    task automatic t_regs();
        logic [7:0]  d;
        logic [7:0]  m;
        logic [11:0] ra [10] = '{OFF_CTRL, OFF_CLK_DIV, OFF_WINDOW,
            OFF_TS_DELAY, OFF_LMFC_LEN, OFF_SYNC_MODE, OFF_FN_LOW,
            OFF_FN_HIGH, OFF_CB_COUNT, 12'h121};
        logic [7:0]  rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [11:0] wa [4] = '{OFF_CLK_DIV, OFF_WINDOW, OFF_FN_LOW,
            OFF_CB_COUNT};
        logic [7:0]  wv [4] = '{8'h07, 8'h0f, 8'h77, 8'hc0};
        for (int i = 0; i < 10; i++) begin
            rd(ra[i], d);
            `CHK(d, rv[i])
        end
        for (int i = 0; i < 4; i++) begin
            wr(wa[i], 8'hff);
            rd(wa[i], d);
            `CHK(d, wv[i])
            wr(wa[i], 8'h00);
        end
        rd(OFF_MONITOR, m);
        wr(OFF_MONITOR, ~m);
        rd(OFF_MONITOR, d);
        `CHK(d, m)
        $display("test regs done");
    endtask : t_regs

    // counted shot: two ignored events, then one acted on
    task automatic t_shot();
        logic [7:0] d;
        int n0;
        src.set_det(4'h8, 4'h0);
        wr(OFF_IGNORE, 8'h02);
        wr(OFF_CTRL, 8'h04);
        rd(OFF_CTRL, d);
        `CHK(d, 8'h04)
        rd(OFF_STATUS, d);
        `CHK(d, 8'h22)
        n0 = n_sync;
        repeat (2) src.pulse(1'b0, 2, 10);
        `CHK(n_sync, n0)
        rd(OFF_STATUS, d);
        `CHK(d, 8'h20)
        src.pulse(1'b0, 2, 10);
        `CHK(n_sync, n0 + 1)
        lat0 = sync_cyc - src.edge_cyc;
        rd(OFF_CTRL, d);
        `CHK(d, 8'h00)
        rd(OFF_MONITOR, d);
        `CHK(d, 8'h08)
        src.pulse(1'b0, 2, 10);
        `CHK(n_sync, n0 + 1)
        $display("test shot done");
    endtask : t_shot

    // transition polarity and capture edge selection
    task automatic t_edges();
        int n0;
        wr(OFF_IGNORE, 8'h00);
        wr(OFF_CTRL, 8'h14);
        src.pulse(1'b0, 12, 10);
        `CHK(sync_cyc - src.edge_cyc, lat0 + 12)
        wr(OFF_CTRL, 8'h0c);
        n0 = n_sync;
        src.pulse(1'b1, 2, 10);
        `CHK(n_sync, n0 + 1)
        wr(OFF_CTRL, 8'h04);
        src.pulse(1'b1, 2, 10);
        `CHK(n_sync, n0 + 1)
        src.pulse(1'b0, 2, 10);
        `CHK(n_sync, n0 + 2)
        $display("test edges done");
    endtask : t_edges

    task automatic t_stamp();
        int n0;
        int t0;
        int l0;
        wr(OFF_SYNC_MODE, 8'h01);
        wr(OFF_CB_COUNT, 8'h40);
        wr(OFF_FN_HIGH, 8'h05);
        wr(OFF_CTRL, 8'h04);
        n0 = n_sync;
        t0 = n_ts;
        src.pulse(1'b0, 2, 12);
        `CHK(n_ts, t0 + 1)
        `CHK(ts_val, 3'h4)
        `CHK(n_sync, n0)
        l0 = ts_cyc - src.edge_cyc;
        wr(OFF_TS_DELAY, 8'h03);
        wr(OFF_CTRL, 8'h04);
        src.pulse(1'b0, 2, 12);
        `CHK(ts_cyc - src.edge_cyc, l0 + 3)
        wr(OFF_CB_COUNT, 8'h80);
        wr(OFF_FN_LOW, 8'h50);
        wr(OFF_FN_HIGH, 8'h00);
        wr(OFF_CTRL, 8'h04);
        src.pulse(1'b0, 2, 12);
        `CHK(ts_val, 3'h2)
        wr(OFF_CB_COUNT, 8'h40);
        wr(OFF_CTRL, 8'h04);
        src.pulse(1'b0, 2, 12);
        `CHK(n_ts, t0 + 3)
        wr(OFF_FN_HIGH, 8'h05);
        wr(OFF_CTRL, 8'h04);
        @(posedge ref_clk_i) decimation_i <= 1'b1;
        src.pulse(1'b0, 2, 12);
        `CHK(n_ts, t0 + 3)
        @(posedge ref_clk_i) decimation_i <= 1'b0;
        `CHK(n_sync, n0)
        wr(OFF_CTRL, 8'h00);
        wr(OFF_SYNC_MODE, 8'h00);
        $display("test stamp done");
    endtask : t_stamp

    // continuous reference against a four-cycle multiframe
    task automatic t_cont();
        int n0;
        int r0;
        wr(OFF_LMFC_LEN, 8'h04);
        wr(OFF_WINDOW, 8'h00);
        wr(OFF_CTRL, 8'h02);
        n0 = n_sync;
        r0 = n_resync;
        repeat (3) src.pulse(1'b0, 2, 6);
        src.pulse(1'b0, 2, 7);
        `CHK(n_sync, n0 + 1)
        `CHK(n_resync, r0)
        fork
            src.pulse(1'b0, 2, 7);
            begin
                repeat (6) @(posedge ref_clk_i);
                wr(OFF_WINDOW, 8'h05);
            end
        join
        `CHK(n_resync, r0 + 1)
        src.pulse(1'b0, 2, 7);
        `CHK(n_resync, r0 + 1)
        src.pulse(1'b0, 2, 8);
        `CHK(n_resync, r0 + 2)
        // phase 2 is outside, then phase 3 sits in the negative window
        src.pulse(1'b0, 2, 9);
        `CHK(n_resync, r0 + 3)
        src.pulse(1'b0, 2, 8);
        `CHK(n_resync, r0 + 3)
        wr(OFF_CTRL, 8'h00);
        $display("test cont done");
    endtask : t_cont

    initial begin
        repeat (16) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        t_regs();
        t_shot();
        t_edges();
        t_stamp();
        t_cont();
        repeat (10) @(posedge ref_clk_i);
        print_verdict();
    end
endmodule : ref_capture_bench
